//--- include/fcs_pkg.sv
// package for the flash command sequencer host controller
package fcs_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
    localparam logic [7:0] AS_MFR = 8'h00;
    localparam logic [7:0] AS_DEV = 8'h01;
    localparam logic [7:0] AS_PROT = 8'h02;
    localparam int SECT_LSB = 16;
    // software register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    // operation codes written to the control register
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_RESET = 4'h1;
    localparam logic [3:0] OP_AUTOSEL = 4'h2;
    localparam logic [3:0] OP_PROG = 4'h3;
    localparam logic [3:0] OP_BYP_ENTER = 4'h4;
    localparam logic [3:0] OP_BYP_PROG = 4'h5;
    localparam logic [3:0] OP_BYP_EXIT = 4'h6;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h7;
    localparam logic [3:0] OP_SECT_ERASE = 4'h8;
    localparam logic [3:0] OP_SECT_ADD = 4'h9;
    // bus timing in core cycles (40 MHz)
    localparam int CLK_MHZ = 40;
    localparam int T_SETUP = 1;
    localparam int T_STROBE = 2;
    localparam int T_HOLD = 1;
    localparam int T_READ = 3;
    localparam int SE_WINDOW_US = 50;
    localparam int SE_WINDOW_CYC = SE_WINDOW_US * CLK_MHZ;
    localparam int STAT_BUSY = 0;
    localparam int STAT_BYPASS = 1;
    localparam int STAT_AUTOSEL = 2;
    localparam int STAT_RDY = 3;
    localparam int STAT_SEWIN = 4;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
    } fcs_ctl_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SETUP = 4'h1,
        ST_STROBE = 4'h2,
        ST_HOLD = 4'h3,
        ST_RD_SETUP = 4'h4,
        ST_RD_WAIT = 4'h5,
        ST_NEXT = 4'h6
    } fcs_state_t;
endpackage

//--- design/fcs_host.sv
// host controller that issues command series to a byte-wide nor flash
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - every operation is a fixed write series; a wrong write drops to array read
// - host writes reset after timeout flag or to leave autoselect
// - autoselect entered by two unlocks and 90; reads repeat freely
// - byte program is two unlocks, a0, then address and data
// - unlock bypass entered by two unlocks then 20
// - bypass program is a0 then address and data, repeated per byte
// - bypass exit is 90 then 00, addresses ignored
// - chip erase is six writes ending in 10
// - sector erase is six writes ending in sector address with 30
// - extra sectors added within 50 us of previous erase write
module fcs_host #(
    parameter int SE_WINDOW = fcs_pkg::SE_WINDOW_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_flash_ce_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n,
    output logic [fcs_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [fcs_pkg::DATA_W-1:0] o_flash_dq_o,
    output logic o_flash_dq_oe,
    input wire logic [fcs_pkg::DATA_W-1:0] i_flash_dq,
    input wire logic i_ready_busy_n,
    output logic o_accel_en
);
    fcs_pkg::fcs_state_t state_q;
    fcs_pkg::fcs_ctl_t ctl_q;
    logic [3:0] op_q;
    logic [2:0] step_q;
    logic [2:0] nsteps_q;
    logic [3:0] cnt_q;
    logic [fcs_pkg::ADDR_W-1:0] tgt_addr_q;
    logic [7:0] tgt_data_q;
    logic [7:0] rdata_q;
    logic bypass_q;
    logic autosel_q;
    logic accel_q;
    logic [31:0] win_q;
    logic [7:0] cyc_data;
    logic cyc_tgt;
    logic cyc_read;
    logic busy;

    assign busy = (state_q != fcs_pkg::ST_IDLE);

    function automatic logic [2:0] op_len(input logic [3:0] op);
        case (op)
            fcs_pkg::OP_READ: op_len = 3'd1;
            fcs_pkg::OP_RESET: op_len = 3'd1;
            fcs_pkg::OP_AUTOSEL: op_len = 3'd4;
            fcs_pkg::OP_PROG: op_len = 3'd4;
            fcs_pkg::OP_BYP_ENTER: op_len = 3'd3;
            fcs_pkg::OP_BYP_PROG: op_len = 3'd2;
            fcs_pkg::OP_BYP_EXIT: op_len = 3'd2;
            fcs_pkg::OP_CHIP_ERASE: op_len = 3'd6;
            fcs_pkg::OP_SECT_ERASE: op_len = 3'd6;
            fcs_pkg::OP_SECT_ADD: op_len = 3'd1;
            default: op_len = 3'd1;
        endcase
    endfunction

    function automatic logic [7:0] unlock(input logic [2:0] s);
        unlock = (s[0] == 1'b0) ? fcs_pkg::CMD_UNLOCK1 : fcs_pkg::CMD_UNLOCK2;
    endfunction

    // data, target-address use and direction of the current cycle
    always_comb
    begin
        cyc_data = fcs_pkg::CMD_RESET;
        cyc_tgt = 1'b0;
        cyc_read = 1'b0;
        case (op_q)
            fcs_pkg::OP_READ:
            begin
                cyc_read = 1'b1;
                cyc_tgt = 1'b1;
            end
            fcs_pkg::OP_RESET: cyc_data = fcs_pkg::CMD_RESET;
            fcs_pkg::OP_AUTOSEL:
            begin
                cyc_data = (step_q < 3'd2) ? unlock(step_q) : fcs_pkg::CMD_AUTOSEL;
                cyc_read = (step_q == 3'd3);
                cyc_tgt = (step_q == 3'd3);
            end
            fcs_pkg::OP_PROG:
            begin
                cyc_data = (step_q < 3'd2) ? unlock(step_q) :
                           (step_q == 3'd2) ? fcs_pkg::CMD_PROG : tgt_data_q;
                cyc_tgt = (step_q == 3'd3);
            end
            fcs_pkg::OP_BYP_ENTER:
                cyc_data = (step_q < 3'd2) ? unlock(step_q) : fcs_pkg::CMD_BYPASS;
            fcs_pkg::OP_BYP_PROG:
            begin
                cyc_data = (step_q == 3'd0) ? fcs_pkg::CMD_PROG : tgt_data_q;
                cyc_tgt = (step_q == 3'd1);
            end
            fcs_pkg::OP_BYP_EXIT:
                cyc_data = (step_q == 3'd0) ? fcs_pkg::CMD_AUTOSEL :
                           fcs_pkg::CMD_BYPASS_EXIT2;
            fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECT_ERASE:
            begin
                if (step_q == 3'd2)
                    cyc_data = fcs_pkg::CMD_ERASE_SETUP;
                else if (step_q < 3'd5)
                    // second unlock pair sits at steps 3 and 4
                    cyc_data = unlock((step_q > 3'd2) ? step_q + 3'd1 : step_q);
                else if (op_q == fcs_pkg::OP_CHIP_ERASE)
                    cyc_data = fcs_pkg::CMD_CHIP_ERASE;
                else
                    cyc_data = fcs_pkg::CMD_SECTOR_ERASE;
                cyc_tgt = (op_q == fcs_pkg::OP_SECT_ERASE) && (step_q == 3'd5);
            end
            fcs_pkg::OP_SECT_ADD:
            begin
                cyc_data = fcs_pkg::CMD_SECTOR_ERASE;
                cyc_tgt = 1'b1;
            end
            default: cyc_data = fcs_pkg::CMD_RESET;
        endcase
    end

    // bus cycle sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= fcs_pkg::ST_IDLE;
            ctl_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
            step_q <= 3'd0;
            nsteps_q <= 3'd1;
            cnt_q <= 4'h0;
            o_flash_addr <= '0;
            o_flash_dq_o <= 8'h00;
            o_flash_dq_oe <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                fcs_pkg::ST_IDLE:
                begin
                    ctl_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
                    o_flash_dq_oe <= 1'b0;
                    step_q <= 3'd0;
                    cnt_q <= 4'h0;
                    if (i_reg_wr && i_reg_addr == fcs_pkg::REG_CTRL)
                    begin
                        nsteps_q <= op_len(i_reg_wdata[3:0]);
                        state_q <= fcs_pkg::ST_NEXT;
                    end
                end
                fcs_pkg::ST_NEXT:
                begin
                    // address ignored by the device on unlock and command writes
                    o_flash_addr <= cyc_tgt ? tgt_addr_q : '0;
                    o_flash_dq_o <= cyc_data;
                    o_flash_dq_oe <= !cyc_read;
                    ctl_q.ce_n <= 1'b0;
                    cnt_q <= 4'h0;
                    state_q <= cyc_read ? fcs_pkg::ST_RD_SETUP : fcs_pkg::ST_SETUP;
                end
                fcs_pkg::ST_SETUP:
                begin
                    // address settles before the strobe falls
                    ctl_q.we_n <= 1'b0;
                    state_q <= fcs_pkg::ST_STROBE;
                end
                fcs_pkg::ST_STROBE:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(fcs_pkg::T_STROBE - 1))
                    begin
                        ctl_q.we_n <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= fcs_pkg::ST_HOLD;
                    end
                end
                fcs_pkg::ST_HOLD:
                begin
                    ctl_q.ce_n <= 1'b1;
                    step_q <= step_q + 3'd1;
                    state_q <= (step_q + 3'd1 == nsteps_q) ? fcs_pkg::ST_IDLE :
                               fcs_pkg::ST_NEXT;
                end
                fcs_pkg::ST_RD_SETUP:
                begin
                    ctl_q.oe_n <= 1'b0;
                    state_q <= fcs_pkg::ST_RD_WAIT;
                end
                fcs_pkg::ST_RD_WAIT:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(fcs_pkg::T_READ - 1))
                    begin
                        rdata_q <= i_flash_dq;
                        ctl_q.oe_n <= 1'b1;
                        state_q <= fcs_pkg::ST_HOLD;
                    end
                end
                default: state_q <= fcs_pkg::ST_IDLE;
            endcase
        end
    end

    // target address and data registers
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tgt_addr_q <= '0;
            tgt_data_q <= 8'h00;
            op_q <= fcs_pkg::OP_READ;
            accel_q <= 1'b0;
        end
        else if (i_reg_wr && !busy)
        begin
            if (i_reg_addr == fcs_pkg::REG_ADDR)
                tgt_addr_q <= i_reg_wdata[fcs_pkg::ADDR_W-1:0];
            else if (i_reg_addr == fcs_pkg::REG_WDATA)
                tgt_data_q <= i_reg_wdata[7:0];
            else if (i_reg_addr == fcs_pkg::REG_CTRL)
            begin
                op_q <= i_reg_wdata[3:0];
                // accelerate only for a bypass program op with bit 8 set, held until the next control write
                accel_q <= i_reg_wdata[8] && (i_reg_wdata[3:0] == fcs_pkg::OP_BYP_PROG);
            end
        end
        else if (!busy && op_q != fcs_pkg::OP_BYP_PROG)
            accel_q <= 1'b0;
    end

    // tracked device mode
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bypass_q <= 1'b0;
            autosel_q <= 1'b0;
        end
        else if (state_q == fcs_pkg::ST_HOLD && step_q + 3'd1 == nsteps_q)
        begin
            if (op_q == fcs_pkg::OP_BYP_ENTER)
                bypass_q <= 1'b1;
            else if (op_q == fcs_pkg::OP_BYP_EXIT || op_q == fcs_pkg::OP_RESET)
                bypass_q <= 1'b0;
            if (op_q == fcs_pkg::OP_AUTOSEL)
                autosel_q <= 1'b1;
            else if (op_q == fcs_pkg::OP_RESET)
                autosel_q <= 1'b0;
        end
    end

    // sector erase add window counter
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            win_q <= 32'h0;
        else if (state_q == fcs_pkg::ST_STROBE && cnt_q == 4'(fcs_pkg::T_STROBE - 1) &&
                 (op_q == fcs_pkg::OP_SECT_ADD ||
                  (op_q == fcs_pkg::OP_SECT_ERASE && step_q == 3'd5)))
            win_q <= 32'(SE_WINDOW);
        else if (win_q != 32'h0)
            win_q <= win_q - 32'h1;
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_reg_rdata <= 32'h0;
        else if (i_reg_rd)
        begin
            if (i_reg_addr == fcs_pkg::REG_CTRL)
                o_reg_rdata <= {23'h0, accel_q, 4'h0, op_q};
            else if (i_reg_addr == fcs_pkg::REG_ADDR)
                o_reg_rdata <= {10'h0, tgt_addr_q};
            else if (i_reg_addr == fcs_pkg::REG_WDATA)
                o_reg_rdata <= {24'h0, tgt_data_q};
            else if (i_reg_addr == fcs_pkg::REG_STATUS)
                o_reg_rdata <= {27'h0, (win_q != 32'h0), i_ready_busy_n, autosel_q,
                                bypass_q, busy};
            else if (i_reg_addr == fcs_pkg::REG_RDATA)
                o_reg_rdata <= {24'h0, rdata_q};
            else
                o_reg_rdata <= 32'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_flash_ce_n <= 1'b1;
            o_flash_we_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            o_accel_en <= 1'b0;
        end
        else
        begin
            o_flash_ce_n <= ctl_q.ce_n;
            o_flash_we_n <= ctl_q.we_n;
            o_flash_oe_n <= ctl_q.oe_n;
            o_accel_en <= accel_q;
        end
    end
endmodule // fcs_host
`default_nettype wire

//--- bench/fcs_host_chk.sv
// pin-level assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_host_chk (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic o_flash_ce_n,
    input wire logic o_flash_we_n,
    input wire logic o_flash_oe_n,
    input wire logic [fcs_pkg::ADDR_W-1:0] o_flash_addr,
    input wire logic o_flash_dq_oe,
    input wire logic o_accel_en
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    property p_we_in_ce;
        !o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n && o_flash_dq_oe;
    endproperty
    a_we_in_ce: assert property (p_we_in_ce) else $error("stray write strobe");
    property p_we_len;
        $fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n;
    endproperty
    a_we_len: assert property (p_we_len) else $error("write pulse length");
    property p_ce_first;
        $fell(o_flash_we_n) |-> $past(o_flash_ce_n) == 1'b0;
    endproperty
    a_ce_first: assert property (p_ce_first) else $error("select not first");
    property p_ce_last;
        $rose(o_flash_we_n) |-> !o_flash_ce_n ##1 o_flash_ce_n;
    endproperty
    a_ce_last: assert property (p_ce_last) else $error("select not last");
    property p_addr_hold;
        !o_flash_we_n |-> $stable(o_flash_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_oe_len;
        $fell(o_flash_oe_n) |-> !o_flash_oe_n [*3] ##1 o_flash_oe_n;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("read pulse length");
    property p_accel;
        o_accel_en |-> o_flash_oe_n;
    endproperty
    a_accel: assert property (p_accel) else $error("read under high voltage");
    property p_rst;
        $rose(i_rst_b) |-> o_flash_ce_n && o_flash_we_n && o_flash_oe_n && !o_flash_dq_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("bus busy after reset");
    c_write: cover property ($fell(o_flash_we_n));
    c_read: cover property ($fell(o_flash_oe_n));
    c_accel: cover property ($rose(o_accel_en));
endmodule // fcs_host_chk
`default_nettype wire

//--- bench/fcs_fm.sv
// behavioural flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_fm #(
    parameter logic [7:0] MFR = 8'h3c, // arbitrary
    parameter logic [7:0] DEV = 8'hc5 // arbitrary
) (
    input wire logic i_clk,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_accel,
    input wire logic [21:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_ready_busy_n
);
    logic [7:0] mem [int];
    logic [21:0] wa [$];
    logic [7:0] wd [$];
    logic [21:0] lat_a = 22'h0;
    logic [7:0] h1 = 8'h0, h2 = 8'h0, last = 8'h0;
    logic armed = 1'b0, asel = 1'b0, byp = 1'b0;
    int busy = 0;
    function automatic logic [7:0] rd_val(input logic [21:0] a);
        if (asel)
            return a[7:0] == 8'h00 ? MFR : a[7:0] == 8'h01 ? DEV : {7'h0, a[21]};
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    task automatic do_wr(input logic [21:0] a, input logic [7:0] d);
        wa.push_back(a);
        wd.push_back(d);
        if (busy > 0 && d != 8'h30)
            return;
        if (h1 == 8'ha0 && (h2 == 8'h55 || byp || i_accel))
        begin
            mem[a] = rd_val(a) & d;
            busy = 8;
            d = 8'h00;
        end
        else if (d == 8'hf0)
            asel = 1'b0;
        else if (h2 == 8'haa && h1 == 8'h55 && d == 8'h90)
            asel = 1'b1;
        else if (h2 == 8'haa && h1 == 8'h55 && d == 8'h20)
            byp = 1'b1;
        else if (byp && h1 == 8'h90 && d == 8'h00)
            byp = 1'b0;
        else if (h1 == 8'h55 && d == 8'h10)
        begin
            mem.delete();
            busy = 8;
        end
        else if (d == 8'h30)
            busy = 80;
        h2 = (d == 8'h00) ? 8'h00 : h1;
        h1 = d;
    endtask
    // released bus shows the inverse of the last byte driven
    assign o_dq = (!i_oe_n && !i_ce_n) ? rd_val(i_addr) : ~last;
    assign o_ready_busy_n = (busy == 0);
    always @(posedge i_clk)
    begin
        if (!i_oe_n && !i_ce_n)
            last = rd_val(i_addr);
        if (busy > 0)
            busy = busy - 1;
    end
    always @(negedge i_ce_n or negedge i_we_n)
        if (!i_ce_n && !i_we_n && i_oe_n)
        begin
            lat_a = i_addr;
            armed = 1'b1;
        end
    always @(posedge i_ce_n or posedge i_we_n)
        if (armed)
        begin
            armed = 1'b0;
            do_wr(lat_a, i_dq);
        end
endmodule // fcs_fm
`default_nettype wire

//--- bench/fcs_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_host_tb;
    typedef logic [7:0] fcs_bq_t [$];
    logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [3:0] ra = 4'h0;
    logic [31:0] rw = 32'h0;
    logic ce_n, we_n, oe_n, dq_oe, accel, rbn;
    logic [31:0] rdat, got;
    logic [21:0] fa, a;
    logic [7:0] dqo, dqi, d;
    logic [7:0] tb_mem [int];
    int bad_count = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    fcs_host #(.SE_WINDOW(40)) fcs_host_inst (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
        .o_reg_rdata(rdat), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n),
        .o_flash_addr(fa), .o_flash_dq_o(dqo), .o_flash_dq_oe(dq_oe), .i_flash_dq(dqi),
        .i_ready_busy_n(rbn), .o_accel_en(accel));
    fcs_fm fcs_fm_inst (.i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_accel(accel), .i_addr(fa), .i_dq(dqo), .o_dq(dqi), .o_ready_busy_n(rbn));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string s);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge clk);
        ra <= ad;
        rw <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clk);
        ra <= ad;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 got = rdat;
    endtask
    task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do
        begin
            rd(fcs_pkg::REG_STATUS);
            n++;
        end
        while ((got & m) !== v && n < 300);
        if (n >= 300)
            cmp(got & m, v, "status wait");
    endtask
    function automatic fcs_bq_t seq_of(input logic [3:0] o, input logic [7:0] v);
        case (o)
            4'h1: return '{8'hf0};
            4'h2: return '{8'haa, 8'h55, 8'h90};
            4'h3: return '{8'haa, 8'h55, 8'ha0, v};
            4'h4: return '{8'haa, 8'h55, 8'h20};
            4'h5: return '{8'ha0, v};
            4'h6: return '{8'h90, 8'h00};
            4'h7: return '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h10};
            4'h8: return '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h30};
            4'h9: return '{8'h30};
            default: return '{};
        endcase
    endfunction
    function automatic logic [31:0] exp_rd(input logic [21:0] ad, input logic as);
        if (as)
            return ad[7:0] == 8'h00 ? 32'h3c : ad[7:0] == 8'h01 ? 32'hc5 : {31'h0, ad[21]};
        return tb_mem.exists(ad) ? {24'h0, tb_mem[ad]} : 32'hff;
    endfunction
    // issue one operation and compare the flash writes it produced
    task automatic op(input logic [3:0] o, input logic [21:0] ad, input logic [7:0] v,
        input logic ac);
        fcs_bq_t e;
        logic ha;
        wr(fcs_pkg::REG_ADDR, {10'h0, ad});
        wr(fcs_pkg::REG_WDATA, {24'h0, v});
        wr(fcs_pkg::REG_CTRL, {23'h0, ac, 4'h0, o});
        wait_st(32'h1, 32'h0);
        e = seq_of(o, v);
        ha = o inside {4'h3, 4'h5, 4'h8, 4'h9};
        cmp(32'(fcs_fm_inst.wd.size()), 32'(e.size()), "write count");
        foreach (e[i])
        begin
            cmp({24'h0, fcs_fm_inst.wd[i]}, {24'h0, e[i]}, "write data");
            cmp({10'h0, fcs_fm_inst.wa[i]}, (ha && i == e.size() - 1) ? {10'h0, ad} : 32'h0,
                "write addr");
        end
        fcs_fm_inst.wd.delete();
        fcs_fm_inst.wa.delete();
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        void'($urandom(95249));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cmp({27'h0, ce_n, we_n, oe_n, dq_oe, accel}, 32'h1c, "idle pins");
        rd(4'hf);
        cmp(got, 32'h0, "unmapped read");
        wait_st(32'h1f, 32'h8);
        $display("test reset done");
        op(fcs_pkg::OP_AUTOSEL, {14'($urandom()), 8'h00}, 8'h0, 1'b0);
        wait_st(32'h4, 32'h4);
        for (int i = 0; i < 4; i++)
        begin
            a = (i < 3) ? {6'($urandom()), 8'h0, 6'h0, 2'(i)} : 22'h0;
            if (i > 0)
                op(fcs_pkg::OP_READ, a, 8'h0, 1'b0);
            rd(fcs_pkg::REG_RDATA);
            cmp(got, exp_rd(a, 1'b1), "ident read");
        end
        op(fcs_pkg::OP_RESET, 22'h0, 8'h0, 1'b0);
        wait_st(32'h4, 32'h0);
        $display("test autoselect done");
        for (int i = 0; i < 4; i++)
        begin
            if (i % 2 == 0)
                a = 22'($urandom());
            d = 8'($urandom());
            op(fcs_pkg::OP_PROG, a, d, 1'b0);
            tb_mem[a] = 8'(exp_rd(a, 1'b0)) & d;
            wait_st(32'h9, 32'h8);
            op(fcs_pkg::OP_READ, a, 8'h0, 1'b0);
            rd(fcs_pkg::REG_RDATA);
            cmp(got, exp_rd(a, 1'b0), "program read back");
        end
        $display("test program done");
        wr(fcs_pkg::REG_CTRL, {28'h0, fcs_pkg::OP_PROG});
        wr(fcs_pkg::REG_CTRL, {28'h0, fcs_pkg::OP_RESET});
        wait_st(32'h9, 32'h8);
        cmp(32'(fcs_fm_inst.wd.size()), 32'h4, "refused op count");
        cmp({24'h0, fcs_fm_inst.wd[3]}, 32'h0, "refused op data");
        fcs_fm_inst.wd.delete();
        fcs_fm_inst.wa.delete();
        op(fcs_pkg::OP_CHIP_ERASE, a, 8'h0, 1'b0);
        wait_st(32'h9, 32'h8);
        $display("test busy refusal done");
        tb_mem.delete();
        op(fcs_pkg::OP_BYP_ENTER, 22'h0, 8'h0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            a = 22'($urandom());
            d = 8'($urandom());
            wait_st(32'hb, 32'ha);
            op(fcs_pkg::OP_BYP_PROG, a, d, i == 2);
            cmp({31'h0, accel}, {31'h0, i == 2}, "accel pin");
            tb_mem[a] = 8'(exp_rd(a, 1'b0)) & d;
        end
        wait_st(32'h9, 32'h8);
        op(fcs_pkg::OP_BYP_EXIT, 22'h0, 8'h0, 1'b0);
        wait_st(32'h2, 32'h0);
        op(fcs_pkg::OP_READ, a, 8'h0, 1'b0);
        rd(fcs_pkg::REG_RDATA);
        cmp(got, exp_rd(a, 1'b0), "bypass read back");
        $display("test bypass done");
        a = {6'($urandom()), 16'h0};
        op(fcs_pkg::OP_SECT_ERASE, a, 8'h0, 1'b0);
        rd(fcs_pkg::REG_STATUS);
        cmp(got & 32'h10, 32'h10, "erase window open");
        op(fcs_pkg::OP_SECT_ADD, a ^ 22'h010000, 8'h0, 1'b0);
        wait_st(32'h19, 32'h8);
        $display("test sector erase done");
        end_of_test();
    end
    initial
    begin
        #(25 * 20000);
        bad_count++;
        end_of_test();
    end
endmodule // fcs_host_tb
bind fcs_host fcs_host_chk fcs_host_chk_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .o_flash_ce_n(o_flash_ce_n), .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n),
    .o_flash_addr(o_flash_addr), .o_flash_dq_oe(o_flash_dq_oe), .o_accel_en(o_accel_en));
`default_nettype wire
